// >>> rtl/spx_pkg.sv
// Register map, field layout and reset values of the synthesizer and aux output bank
package spx_pkg;
  localparam int SPX_ADDR_W = 15;
  localparam int SPX_FRAME_BITS = 24;
  localparam int SPX_LANES = 8;
  // Register addresses
  localparam logic [14:0] SPX_ADDR_FIRST_SECOND_DIV = 15'h003D;
  localparam logic [14:0] SPX_ADDR_THIRD_DIV = 15'h003E;
  localparam logic [14:0] SPX_ADDR_OSC_BIAS = 15'h003F;
  localparam logic [14:0] SPX_ADDR_PREEMPH = 15'h0048;
  localparam logic [14:0] SPX_ADDR_TRIG_CTRL = 15'h0057;
  localparam logic [14:0] SPX_ADDR_PIN_OVR = 15'h0058;
  // Reset values
  localparam logic [7:0] SPX_RST_FIRST_SECOND_DIV = 8'h00;
  localparam logic [7:0] SPX_RST_THIRD_DIV = 8'h20;
  localparam logic [7:0] SPX_RST_OSC_BIAS = 8'h4F;
  localparam logic [7:0] SPX_RST_PREEMPH = 8'h00;
  localparam logic [7:0] SPX_RST_TRIG_CTRL = 8'h00;
  localparam logic [7:0] SPX_RST_PIN_OVR = 8'h00;
  // Writable field masks; reserved bits read as zero
  localparam logic [7:0] SPX_MASK_FIRST_SECOND_DIV = 8'h0F;
  localparam logic [7:0] SPX_MASK_THIRD_DIV = 8'h3F;
  localparam logic [7:0] SPX_MASK_OSC_BIAS = 8'h7F;
  localparam logic [7:0] SPX_MASK_PREEMPH = 8'h0F;
  localparam logic [7:0] SPX_MASK_TRIG_CTRL = 8'h87;
  localparam logic [7:0] SPX_MASK_PIN_OVR = 8'hBF;
  // Field positions
  localparam int SPX_FIRST_DIV_LSB = 0;
  localparam int SPX_SECOND_DIV_LSB = 2;
  localparam int SPX_TRIG_EN_BIT = 7;
  localparam int SPX_TRIG_FN_LSB = 0;
  localparam int SPX_OVR_EN_BIT = 7;
  localparam int SPX_REF_D_LSB = 4;
  localparam int SPX_REF_C_LSB = 2;
  localparam int SPX_OVR_SE_BIT = 1;
  localparam int SPX_OVR_PLL_EN_BIT = 0;
  // Decoded ratios at reset
  localparam logic [2:0] SPX_RST_FIRST_RATIO = 3'h5;
  localparam logic [2:0] SPX_RST_SECOND_RATIO = 3'h1;
  localparam logic [5:0] SPX_RST_THIRD_RATIO = 6'h20;
  // Aux output function codes
  localparam logic [2:0] SPX_AUX_UI16 = 3'h0;
  localparam logic [2:0] SPX_AUX_UI32 = 3'h1;
  localparam logic [2:0] SPX_AUX_UI64 = 3'h2;
  localparam logic [2:0] SPX_AUX_TSTAMP = 3'h3;
  typedef enum logic [2:0] {
    SPX_SPI_IDLE = 3'b001,
    SPX_SPI_SHIFT = 3'b010,
    SPX_SPI_DONE = 3'b100
  } spx_spi_state_t;
endpackage : spx_pkg

// >>> rtl/spx_serial_port.sv
// Serial control port: 24-bit frames of read flag, 15-bit address and 8-bit data
`timescale 1ns/1ns
module spx_serial_port
  import spx_pkg::*;
(
  // Clock and reset
  input wire logic clk_sys,
  input wire logic srst,
  // Serial pins, sampled synchronously
  input wire logic spi_sclk,
  input wire logic spi_cs_n,
  input wire logic spi_sdi,
  output logic spi_sdo,
  output logic spi_sdo_oe,
  // Register side
  output logic [14:0] reg_addr,
  output logic [7:0] wr_data,
  output logic wr_pulse,
  input wire logic [7:0] rd_data
);
  spx_spi_state_t state;
  logic sclk_q;
  logic [4:0] bit_cnt;
  logic [23:0] shift_in;
  logic [7:0] shift_out;
  logic is_read;
  wire sclk_rise = spi_sclk & ~sclk_q;
  wire sclk_fall = ~spi_sclk & sclk_q;
  wire [23:0] next_shift = {shift_in[22:0], spi_sdi};
  wire addr_done = sclk_rise && bit_cnt == 5'd15;
  wire frame_done = sclk_rise && bit_cnt == 5'(SPX_FRAME_BITS - 1);

  always_ff @(posedge clk_sys) begin
    sclk_q <= spi_sclk;
    wr_pulse <= 1'b0;
    if (srst || spi_cs_n) begin
      state <= SPX_SPI_IDLE;
      bit_cnt <= 5'h00;
      shift_in <= 24'h000000;
      spi_sdo_oe <= 1'b0;
      if (srst) begin
        reg_addr <= 15'h0000;
        wr_data <= 8'h00;
        shift_out <= 8'h00;
        spi_sdo <= 1'b0;
        is_read <= 1'b0;
      end
    end else begin
      case (state)
        SPX_SPI_IDLE: begin
          state <= SPX_SPI_SHIFT;
        end
        SPX_SPI_SHIFT: begin
          if (sclk_rise) begin
            shift_in <= next_shift;
            bit_cnt <= bit_cnt + 5'd1;
          end
          if (addr_done) begin
            reg_addr <= next_shift[14:0];
            is_read <= next_shift[15];
          end
          // Read data is loaded one cycle after the address settles
          if (bit_cnt == 5'd16 && !sclk_rise && !sclk_fall && spi_sdo_oe == 1'b0 && is_read) begin
            shift_out <= rd_data;
          end
          if (sclk_fall && bit_cnt >= 5'd16 && is_read) begin
            spi_sdo <= shift_out[7];
            shift_out <= {shift_out[6:0], 1'b0};
            spi_sdo_oe <= 1'b1;
          end
          if (frame_done) begin
            wr_data <= next_shift[7:0];
            wr_pulse <= ~is_read;
            state <= SPX_SPI_DONE;
          end
        end
        SPX_SPI_DONE: begin
          // Extra clocks after a full frame are ignored until chip select rises
          state <= SPX_SPI_DONE;
        end
        default: begin
          state <= SPX_SPI_IDLE;
        end
      endcase
    end
  end
endmodule : spx_serial_port

// >>> rtl/spx_synth_cfg.sv
// Synthesizer divider, bias, pre-emphasis, aux trigger and pin-override register bank
//
// Contract
// (RULE1) Second divider code in bits 3:2: 1, 2, 4, reserved.
// (RULE2) First divider code in bits 1:0: 5, 4, 3, reserved; feeds second.
// (RULE3) Host puts synthesizer in reset before changing any feedback divider.
// (RULE4) Third divider bits 5:0 is the ratio, 1 to 63, reset 0x20.
// (RULE5) Host writes bias 0x4A when synthesizer used, not reset 0x4F.
// (RULE6) One 4-bit pre-emphasis setting drives all eight lanes together.
// (RULE7) Trigger control bit 7 enables aux output; disabled at reset.
// (RULE8) Function bits 2:0: 16, 32, 64 UI clock, timestamp; 4-7 reserved.
// (RULE9) Host changes aux function only while aux output is disabled.
// (RULE10) Function codes 2 or less stop briefly on serializer re-initialization.
// (RULE11) Host writes reset values into every reserved field.
// (RULE12) Override bit 7 selects pins when 0, register values when 1.
// (RULE13) Reference output codes: off, ref div 1, div 2, div 4.
// (RULE14) Every read/write field reads back last written or reset value.
`timescale 1ns/1ns
module spx_synth_cfg
  import spx_pkg::*;
#(
  parameter int LANES = SPX_LANES
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic srst,
  // Serial control port
  input wire logic spi_sclk,
  input wire logic spi_cs_n,
  input wire logic spi_sdi,
  output logic spi_sdo,
  output logic spi_sdo_oe,
  // Synthesizer control
  input wire logic synth_loop_reset,
  output logic [2:0] first_div_ratio,
  output logic [2:0] second_div_ratio,
  output logic [5:0] third_div_ratio,
  output logic [6:0] oscillator_bias_level,
  // Serial lanes
  output logic [LANES-1:0][3:0] lane_preemphasis,
  // Aux trigger output
  input wire logic ser_ui_tick,
  input wire logic serializer_reinit,
  input wire logic timestamp_input,
  output logic aux_trigger_output,
  // Pin override
  input wire logic pin_synth_enable,
  input wire logic pin_ref_select_se,
  input wire logic [1:0] pin_clk_cfg,
  input wire logic ref_tick,
  output logic synth_enable,
  output logic ref_select_se,
  output logic ref_out_c,
  output logic ref_out_d
);
  logic [14:0] reg_addr;
  logic [7:0] wr_data;
  logic wr_pulse;
  logic [7:0] rd_data;
  logic [7:0] r_div12;
  logic [7:0] r_div3;
  logic [7:0] r_bias;
  logic [7:0] r_pe;
  logic [7:0] r_trig;
  logic [7:0] r_ovr;
  logic [4:0] aux_cnt;
  logic [2:0] ref_cnt;

  function automatic logic [7:0] wr_val(input logic [14:0] a, input logic [7:0] m,
                                        input logic [7:0] cur);
    wr_val = (wr_pulse && reg_addr == a) ? (wr_data & m) : cur; // see (RULE14)
  endfunction : wr_val

  // Half period minus one, in UI ticks
  function automatic logic [4:0] aux_half(input logic [2:0] fn);
    case (fn)
      SPX_AUX_UI16: aux_half = 5'd7;
      SPX_AUX_UI32: aux_half = 5'd15;
      default: aux_half = 5'd31;
    endcase
  endfunction : aux_half

  // Divide-by-1/2/4 picks a bit of the reference tick counter
  function automatic logic ref_wave(input logic [1:0] fn, input logic [2:0] cnt);
    case (fn)
      2'h1: ref_wave = cnt[0];
      2'h2: ref_wave = cnt[1];
      2'h3: ref_wave = cnt[2];
      default: ref_wave = 1'b0;
    endcase
  endfunction : ref_wave

  spx_serial_port spx_serial_port_i (
    .clk_sys(clk_sys),
    .srst(srst),
    .spi_sclk(spi_sclk),
    .spi_cs_n(spi_cs_n),
    .spi_sdi(spi_sdi),
    .spi_sdo(spi_sdo),
    .spi_sdo_oe(spi_sdo_oe),
    .reg_addr(reg_addr),
    .wr_data(wr_data),
    .wr_pulse(wr_pulse),
    .rd_data(rd_data)
  );

  // Read mux; unmapped addresses read zero
  assign rd_data = (reg_addr == SPX_ADDR_FIRST_SECOND_DIV) ? r_div12 :
                   (reg_addr == SPX_ADDR_THIRD_DIV) ? r_div3 :
                   (reg_addr == SPX_ADDR_OSC_BIAS) ? r_bias :
                   (reg_addr == SPX_ADDR_PREEMPH) ? r_pe :
                   (reg_addr == SPX_ADDR_TRIG_CTRL) ? r_trig :
                   (reg_addr == SPX_ADDR_PIN_OVR) ? r_ovr : 8'h00; // see (RULE14)

  // Masks drop reserved bits so they always read their reset value of zero
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      r_div12 <= SPX_RST_FIRST_SECOND_DIV;
      r_div3 <= SPX_RST_THIRD_DIV; // see (RULE4)
      r_bias <= SPX_RST_OSC_BIAS;
      r_pe <= SPX_RST_PREEMPH;
      r_trig <= SPX_RST_TRIG_CTRL; // see (RULE7)
      r_ovr <= SPX_RST_PIN_OVR;
    end else begin
      r_div12 <= wr_val(SPX_ADDR_FIRST_SECOND_DIV, SPX_MASK_FIRST_SECOND_DIV, r_div12);
      r_div3 <= wr_val(SPX_ADDR_THIRD_DIV, SPX_MASK_THIRD_DIV, r_div3);
      r_bias <= wr_val(SPX_ADDR_OSC_BIAS, SPX_MASK_OSC_BIAS, r_bias);
      r_pe <= wr_val(SPX_ADDR_PREEMPH, SPX_MASK_PREEMPH, r_pe);
      r_trig <= wr_val(SPX_ADDR_TRIG_CTRL, SPX_MASK_TRIG_CTRL, r_trig);
      r_ovr <= wr_val(SPX_ADDR_PIN_OVR, SPX_MASK_PIN_OVR, r_ovr);
    end
  end

  // Divider decoding
  wire [1:0] first_code = r_div12[SPX_FIRST_DIV_LSB +: 2];
  wire [1:0] second_code = r_div12[SPX_SECOND_DIV_LSB +: 2];
  wire [2:0] next_first = (first_code == 2'h3) ? first_div_ratio :
                          3'(3'd5 - {1'b0, first_code}); // see (RULE2)
  wire [2:0] next_second = (second_code == 2'h3) ? second_div_ratio :
                           3'(3'd1 << second_code); // see (RULE1)
  wire [5:0] next_third = (r_div3[5:0] == 6'h00) ? third_div_ratio : r_div3[5:0]; // see (RULE4)

  // Ratios reach the loop only while it is held in reset, so a divider never
  // steps under a running loop; reserved codes keep the last good ratio
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      first_div_ratio <= SPX_RST_FIRST_RATIO;
      second_div_ratio <= SPX_RST_SECOND_RATIO;
      third_div_ratio <= SPX_RST_THIRD_RATIO;
    end else if (synth_loop_reset) begin // see (RULE3)
      first_div_ratio <= next_first;
      second_div_ratio <= next_second;
      third_div_ratio <= next_third;
    end
  end

  // Bias is passed as written; choosing the working value is software's job
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      oscillator_bias_level <= SPX_RST_OSC_BIAS[6:0];
    end else begin
      oscillator_bias_level <= r_bias[6:0]; // see (RULE5)
    end
  end

  genvar gl;
  generate
    for (gl = 0; gl < LANES; gl++) begin : g_lane
      always_ff @(posedge clk_sys) begin
        if (srst) begin
          lane_preemphasis[gl] <= SPX_RST_PREEMPH[3:0];
        end else begin
          lane_preemphasis[gl] <= r_pe[3:0]; // see (RULE6)
        end
      end
    end
  endgenerate

  // Aux trigger output
  wire aux_en = r_trig[SPX_TRIG_EN_BIT];
  wire [2:0] aux_fn = r_trig[SPX_TRIG_FN_LSB +: 3];
  wire aux_ser_mode = aux_fn <= SPX_AUX_UI64;
  wire aux_wrap = ser_ui_tick && aux_cnt == aux_half(aux_fn);
  // Reserved function codes hold the output low; switching the code while enabled
  // may leave one odd-length half period
  wire next_aux = !aux_en ? 1'b0 : // see (RULE7)
                  (aux_fn == SPX_AUX_TSTAMP) ? timestamp_input : // see (RULE8)
                  !aux_ser_mode ? 1'b0 :
                  serializer_reinit ? 1'b0 : // see (RULE10)
                  aux_wrap ? ~aux_trigger_output : aux_trigger_output;

  always_ff @(posedge clk_sys) begin
    if (srst || !aux_en || serializer_reinit) begin
      aux_cnt <= 5'h00;
    end else if (ser_ui_tick) begin
      aux_cnt <= aux_wrap ? 5'h00 : aux_cnt + 5'd1; // see (RULE8)
    end
  end

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      aux_trigger_output <= 1'b0;
    end else begin
      aux_trigger_output <= next_aux;
    end
  end

  // Pin override; with pins in charge the two config pins give the function code
  wire ovr_en = r_ovr[SPX_OVR_EN_BIT];
  wire [1:0] c_fn = ovr_en ? r_ovr[SPX_REF_C_LSB +: 2] : pin_clk_cfg; // see (RULE12)
  wire [1:0] d_fn = ovr_en ? r_ovr[SPX_REF_D_LSB +: 2] : pin_clk_cfg;
  wire next_c = ref_wave(c_fn, ref_cnt); // see (RULE13)
  // Output d needs output c to be running as well
  wire next_d = (c_fn != 2'h0) ? ref_wave(d_fn, ref_cnt) : 1'b0; // see (RULE13)

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      ref_cnt <= 3'h0;
    end else if (ref_tick) begin
      ref_cnt <= ref_cnt + 3'd1;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      synth_enable <= 1'b0;
      ref_select_se <= 1'b0;
      ref_out_c <= 1'b0;
      ref_out_d <= 1'b0;
    end else begin
      synth_enable <= ovr_en ? r_ovr[SPX_OVR_PLL_EN_BIT] : pin_synth_enable; // see (RULE12)
      ref_select_se <= ovr_en ? r_ovr[SPX_OVR_SE_BIT] : pin_ref_select_se; // see (RULE12)
      ref_out_c <= next_c;
      ref_out_d <= next_d;
    end
  end
endmodule : spx_synth_cfg

// >>> verification/spx_synth_cfg_properties.sv
// Port-level checks of the synthesizer configuration bank
`timescale 1ns/1ns
module spx_synth_cfg_properties
  import spx_pkg::*;
#(
  parameter int LANES = SPX_LANES
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic srst,
  // Watched ports
  input wire logic spi_cs_n,
  input wire logic spi_sdo_oe,
  input wire logic synth_loop_reset,
  input wire logic [2:0] first_div_ratio,
  input wire logic [2:0] second_div_ratio,
  input wire logic [5:0] third_div_ratio,
  input wire logic [6:0] oscillator_bias_level,
  input wire logic [LANES-1:0][3:0] lane_preemphasis,
  input wire logic serializer_reinit,
  input wire logic aux_trigger_output
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (srst);
  // Idle spans are long enough to outlast the port's own pipeline
  sequence port_idle; spi_cs_n [*5]; endsequence
  sequence ratios_frozen; !synth_loop_reset [*3]; endsequence
  lanes_equal_a:
    assert property (lane_preemphasis == {LANES{lane_preemphasis[0]}}) else $error("lanes differ");
  first_legal_a:
    assert property (first_div_ratio inside {3'h3, 3'h4, 3'h5}) else $error("bad first ratio");
  second_legal_a:
    assert property (second_div_ratio inside {3'h1, 3'h2, 3'h4}) else $error("bad second ratio");
  third_legal_a:
    assert property (third_div_ratio != 6'h00) else $error("third ratio zero");
  ratios_hold_a:
    assert property (ratios_frozen |-> $stable(first_div_ratio) && $stable(second_div_ratio)
      && $stable(third_div_ratio)) else $error("ratio moved outside loop reset");
  reinit_low_a:
    assert property (serializer_reinit [*2] |-> !aux_trigger_output) else $error("aux not low");
  idle_no_drive_a:
    assert property (spi_cs_n [*3] |-> !spi_sdo_oe) else $error("sdo driven while idle");
  idle_hold_a:
    assert property (port_idle |-> $stable(oscillator_bias_level) && $stable(lane_preemphasis))
      else $error("setting moved while idle");
endmodule : spx_synth_cfg_properties

bind spx_synth_cfg spx_synth_cfg_properties #(.LANES(LANES)) spx_synth_cfg_properties_i (
  .clk_sys, .srst, .spi_cs_n, .spi_sdo_oe, .synth_loop_reset, .first_div_ratio,
  .second_div_ratio, .third_div_ratio, .oscillator_bias_level, .lane_preemphasis,
  .serializer_reinit, .aux_trigger_output);

// >>> verification/tb_spx_synth_cfg.sv
// Self-checking bench of the synthesizer configuration bank
`timescale 1ns/1ns
module tb_spx_synth_cfg;
  import spx_pkg::*;
  logic clk_sys = 0, srst = 1, spi_sclk = 0, spi_cs_n = 1, spi_sdi = 0, synth_loop_reset = 0;
  logic ser_ui_tick = 0, serializer_reinit = 0, timestamp_input = 0;
  logic pin_synth_enable = 0, pin_ref_select_se = 0;
  logic [1:0] pin_clk_cfg = 2'h0;
  logic spi_sdo, spi_sdo_oe, aux_trigger_output, synth_enable, ref_select_se, ref_out_c, ref_out_d;
  logic [2:0] first_div_ratio, second_div_ratio;
  logic [5:0] third_div_ratio;
  logic [6:0] oscillator_bias_level;
  logic [7:0][3:0] lane_preemphasis;
  logic [7:0] q;
  int err_total = 0, check_count = 0, n;
  always #20 clk_sys = ~clk_sys;
  // One tick source feeds both UI and reference inputs: a pulse every second cycle
  always @(posedge clk_sys) ser_ui_tick <= #1 ~ser_ui_tick;
  spx_synth_cfg #(.LANES(8)) spx_synth_cfg_i (.clk_sys, .srst, .spi_sclk, .spi_cs_n, .spi_sdi,
    .spi_sdo, .spi_sdo_oe, .synth_loop_reset, .first_div_ratio, .second_div_ratio,
    .third_div_ratio, .oscillator_bias_level, .lane_preemphasis, .ser_ui_tick,
    .serializer_reinit, .timestamp_input, .aux_trigger_output, .pin_synth_enable,
    .pin_ref_select_se, .pin_clk_cfg, .ref_tick(ser_ui_tick), .synth_enable, .ref_select_se,
    .ref_out_c, .ref_out_d);
  task automatic tick(input int c);
    repeat (c) @(posedge clk_sys);
    #1;
  endtask : tick
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    check_count++;
    if (g !== e) begin
      err_total++;
      $display("wrong value at %0t: got %h expected %h", $time, g, e);
    end
  endtask : chk
  // Each serial level is held four cycles so the synchronous sampler sees it four times
  task automatic xfer(input logic rd, input logic [14:0] a, input logic [7:0] d);
    logic [23:0] f;
    f = {rd, a, d};
    spi_cs_n = 0;
    for (int i = 23; i >= 0; i--) begin
      spi_sdi = f[i];
      tick(4);
      if (i < 8) q[i] = spi_sdo;
      spi_sclk = 1;
      tick(4);
      spi_sclk = 0;
    end
    tick(4);
    spi_cs_n = 1;
    tick(4);
  endtask : xfer
  task automatic wr(input logic [14:0] a, input logic [7:0] d);
    xfer(1'b0, a, d);
    tick(2);
  endtask : wr
  task automatic rchk(input logic [14:0] a, input logic [7:0] e);
    xfer(1'b1, a, 8'h00);
    chk(q, e);
  endtask : rchk
  function automatic logic pick(input int s);
    return s == 0 ? aux_trigger_output : (s == 1 ? ref_out_c : ref_out_d);
  endfunction : pick
  // Half period in cycles; a stuck output times out at 300
  task automatic meas(input int s, output int c);
    logic v;
    int k;
    v = pick(s);
    k = 0;
    while (pick(s) === v && k < 300) begin
      tick(1);
      k++;
    end
    v = pick(s);
    c = 0;
    while (pick(s) === v && c < 300) begin
      tick(1);
      c++;
    end
  endtask : meas
  task automatic t_reset;
    chk({first_div_ratio, second_div_ratio, third_div_ratio}, 12'hA60);
    rchk(SPX_ADDR_FIRST_SECOND_DIV, SPX_RST_FIRST_SECOND_DIV);
    rchk(SPX_ADDR_THIRD_DIV, 8'h20);
    rchk(SPX_ADDR_OSC_BIAS, 8'h4F);
    rchk(SPX_ADDR_PREEMPH, 8'h00);
    rchk(SPX_ADDR_TRIG_CTRL, 8'h00);
    rchk(SPX_ADDR_PIN_OVR, 8'h00);
    rchk(15'h0040, 8'h00);
  endtask : t_reset
  task automatic t_div;
    synth_loop_reset = 1;
    for (int v = 0; v < 3; v++) begin
      for (int p = 0; p < 3; p++) begin
        wr(SPX_ADDR_FIRST_SECOND_DIV, 8'(p * 4 + v));
        chk(first_div_ratio, 5 - v);
        chk(second_div_ratio, 1 << p);
      end
    end
    // Reserved codes only; the reserved upper field is kept at zero
    wr(SPX_ADDR_FIRST_SECOND_DIV, 8'h0F);
    chk({first_div_ratio, second_div_ratio}, 6'h1C);
    rchk(SPX_ADDR_FIRST_SECOND_DIV, 8'h0F);
    wr(SPX_ADDR_THIRD_DIV, 8'h3F);
    chk(third_div_ratio, 6'h3F);
    wr(SPX_ADDR_THIRD_DIV, 8'h01);
    wr(SPX_ADDR_THIRD_DIV, 8'h00);
    chk(third_div_ratio, 6'h01);
    wr(SPX_ADDR_THIRD_DIV, 8'h10);
    chk(third_div_ratio, 6'h10);
    synth_loop_reset = 0;
    tick(4);
    chk(third_div_ratio, 6'h10);
    rchk(SPX_ADDR_THIRD_DIV, 8'h10);
  endtask : t_div
  task automatic t_misc;
    wr(SPX_ADDR_OSC_BIAS, 8'h4A);
    chk(oscillator_bias_level, 7'h4A);
    wr(SPX_ADDR_PREEMPH, 8'h0B);
    chk(lane_preemphasis, {8{4'hB}});
    rchk(SPX_ADDR_PREEMPH, 8'h0B);
  endtask : t_misc
  task automatic t_aux;
    for (int m = 0; m < 3; m++) begin
      // Disable first so the function code never changes under a running output
      if (m > 0) begin
        wr(SPX_ADDR_TRIG_CTRL, 8'(m - 1));
      end
      wr(SPX_ADDR_TRIG_CTRL, 8'(m));
      tick(40);
      chk(aux_trigger_output, 1'b0);
      wr(SPX_ADDR_TRIG_CTRL, 8'(8'h80 | m));
      meas(0, n);
      chk(n, 16 << m);
    end
    serializer_reinit = 1;
    tick(3);
    chk(aux_trigger_output, 1'b0);
    serializer_reinit = 0;
    meas(0, n);
    chk(n, 64);
    wr(SPX_ADDR_TRIG_CTRL, 8'h02);
    wr(SPX_ADDR_TRIG_CTRL, 8'h03);
    wr(SPX_ADDR_TRIG_CTRL, 8'h83);
    timestamp_input = 1;
    tick(3);
    chk(aux_trigger_output, 1'b1);
    timestamp_input = 0;
    tick(3);
    chk(aux_trigger_output, 1'b0);
    wr(SPX_ADDR_TRIG_CTRL, 8'h03);
    wr(SPX_ADDR_TRIG_CTRL, 8'h04);
    wr(SPX_ADDR_TRIG_CTRL, 8'h84);
    timestamp_input = 1;
    tick(40);
    chk(aux_trigger_output, 1'b0);
    rchk(SPX_ADDR_TRIG_CTRL, 8'h84);
  endtask : t_aux
  task automatic t_ovr;
    pin_synth_enable = 1;
    pin_clk_cfg = 2'h2;
    tick(3);
    chk({synth_enable, ref_select_se}, 2'b10);
    meas(1, n);
    chk(n, 4);
    for (int c = 1; c < 4; c++) begin
      wr(SPX_ADDR_PIN_OVR, 8'(8'h82 | c * 4 | c * 16));
      chk({synth_enable, ref_select_se}, 2'b01);
      meas(1, n);
      chk(n, 1 << c);
      meas(2, n);
      chk(n, 1 << c);
    end
    rchk(SPX_ADDR_PIN_OVR, 8'hBE);
    wr(SPX_ADDR_PIN_OVR, 8'h80);
    tick(20);
    chk({ref_out_c, ref_out_d}, 2'b00);
  endtask : t_ovr
  task automatic test_done;
    $display("checks %0d mismatches %0d", check_count, err_total);
    if (err_total == 0 && check_count > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : test_done
  initial begin
    tick(12);
    srst = 0;
    tick(1);
    t_reset;
    t_div;
    t_misc;
    t_aux;
    t_ovr;
    test_done;
  end
  initial begin
    tick(60000);
    err_total++;
    test_done;
  end
endmodule : tb_spx_synth_cfg
